// File: core/uart_rx_regs.svh
// Register map, field positions, reset values and sampling counts
// for the serial receiver. Included by its bare name; definitions only.
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

// ==========================================================
// Register offsets (2-bit address)
`define RX_OFS_STATUS 2'h0
`define RX_OFS_CTRL_B 2'h1
`define RX_OFS_FRAME_CFG 2'h2
`define RX_OFS_DATA 2'h3

// ==========================================================
// rx_status_reg fields
`define RX_ST_COMPLETE 7
`define RX_ST_FRAME_ERR 4
`define RX_ST_OVERRUN 3
`define RX_ST_PARITY_ERR 2
`define RX_ST_DOUBLE_SPEED 1

// ==========================================================
// ctrl_reg_b fields
`define RX_CB_IRQ_EN 7
`define RX_CB_ENABLE 4
`define RX_CB_CHAR_SIZE2 2
`define RX_CB_NINTH_BIT 1

// ==========================================================
// frame_config_reg fields
`define RX_FC_PARITY_HI 5
`define RX_FC_PARITY_LO 4
`define RX_FC_STOP_SEL 3
`define RX_FC_CHAR_SIZE_HI 2
`define RX_FC_CHAR_SIZE_LO 1

// ==========================================================
// Reset values
`define RX_RST_CHAR_SIZE 3'h3
`define RX_RST_PARITY 2'h0

// ==========================================================
// Oversampling and majority-vote sample numbers, nine-bit size code, buffer depth
`define RX_SPB_NORMAL 5'h10
`define RX_SPB_DOUBLE 5'h08
`define RX_VOTE_FIRST_NORMAL 5'h08
`define RX_VOTE_FIRST_DOUBLE 5'h04
`define RX_CHAR_NINE 3'h7
`define RX_BUF_DEPTH 2'h2

`endif

// File: core/uart_rx_pkg.sv
// Types shared by the serial receiver.
// Assumes the constants header is included where numbers are needed.
package uart_rx_pkg;

  // One receive buffer entry: character plus its error flags
  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } rx_entry_t;

  // Receiver sequencing
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS
  } rx_state_t;

endpackage

// File: core/uart_rx_flags.sv
// Serial receiver: clock and data recovery, two-entry buffer with
// per-character error flags, and a small register port.
// Assumes a one-cycle sample strobe from an outside baud generator.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "uart_rx_regs.svh"

// Contract
// - rx_complete high exactly while buffer non-empty
// - clearing rx_enable flushes buffer immediately
// - interrupt asserted while enabled and rx_complete
// - error flags stored per character entry
// - flag writes ignored; flags raise no interrupt
// - first stop bit voted sets frame_error
// - overrun on full buffer, waiting char, start
// - overrun cleared on successful buffer transfer
// - parity_error only when checking was enabled
// - parity checked odd or even when enabled
// - disable stops receiver, releases pin
// - oversample 16x normal, 8x double speed
// - start bit voted on samples 8-10/4-6
// - resynchronise on every accepted start bit
// - 16 or 8 recovery states per bit
// - each bit from three centre samples
// - frame ends at first stop bit
// - next start edge accepted right after vote
// - enable hands pin to receiver
// - ninth bit kept in same entry
// - unused upper data bits read zero
module uart_rx_flags (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sample_tick_i,
  input wire logic receive_pin_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic rx_complete_irq_o,
  output logic pin_override_o
);

  // ==========================================================
  // Decoding helpers

  // Two or three of three wins
  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // 0 none, 1..3 = first, middle, last centre sample
  function automatic logic [1:0] vote_pos(input logic [4:0] ph,
                                          input logic ds);
    logic [4:0] f;
    f = ds ? `RX_VOTE_FIRST_DOUBLE : `RX_VOTE_FIRST_NORMAL;
    if (ph == f)
      vote_pos = 2'h1;
    else if (ph == 5'(f + 5'h01))
      vote_pos = 2'h2;
    else if (ph == 5'(f + 5'h02))
      vote_pos = 2'h3;
    else
      vote_pos = 2'h0;
  endfunction

  // Data bits per character; reserved codes fall back to 5..7
  function automatic logic [3:0] data_bits(input logic [2:0] cs);
    if (cs == `RX_CHAR_NINE)
      data_bits = 4'h9;
    else
      data_bits = 4'({2'h0, cs[1:0]} + 4'h5);
  endfunction

  // ==========================================================
  // Control registers
  logic rx_enable_r;
  logic irq_en_r;
  logic double_speed_r;
  logic stop_sel_r;
  logic [1:0] parity_mode_r;
  logic [2:0] char_size_r;

  // ==========================================================
  // Receiver and buffer state
  uart_rx_pkg::rx_state_t state_r;
  logic [4:0] ph_r;
  logic [2:0] votes_r;
  logic prev_r;
  logic [3:0] bitn_r;
  logic [8:0] data_sh_r;
  logic parity_bit_r;
  logic frame_done_r;
  logic start_ok_r;
  uart_rx_pkg::rx_entry_t frame_r;
  uart_rx_pkg::rx_entry_t hold_r;
  logic hold_valid_r;
  logic dor_flag_r;
  uart_rx_pkg::rx_entry_t buf_r [0:1];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;

  logic [1:0] vp;
  logic vote;
  logic [4:0] spb;
  logic [3:0] nd;
  logic rx_complete;
  logic pop;
  logic room;
  logic src_valid;
  logic push;
  logic overrun_hit;
  uart_rx_pkg::rx_entry_t head;
  uart_rx_pkg::rx_entry_t src;

  // Sampling position and vote of the current tick
  assign spb = double_speed_r ? `RX_SPB_DOUBLE : `RX_SPB_NORMAL;
  assign vp = vote_pos(ph_r, double_speed_r);
  assign vote = maj3(votes_r[1], votes_r[0], receive_pin_i);
  assign nd = data_bits(char_size_r);

  // Buffer handshake terms
  assign head = buf_r[rd_ptr_r];
  assign rx_complete = (count_r != 2'h0);
  assign pop = rd_i && (addr_i == `RX_OFS_DATA) && rx_complete;
  assign room = (count_r != `RX_BUF_DEPTH) || pop;
  assign src_valid = hold_valid_r || frame_done_r;
  assign push = src_valid && room && rx_enable_r;
  assign overrun_hit = start_ok_r && hold_valid_r &&
                       (count_r == `RX_BUF_DEPTH);

  // Entry to write: freshly finished frame or the held one
  always_comb begin
    src = hold_valid_r ? hold_r : frame_r;
    src.overrun = dor_flag_r;
  end

  // ==========================================================
  // Register writes; flag positions are not writable
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_enable_r <= 1'b0;
      irq_en_r <= 1'b0;
      double_speed_r <= 1'b0;
      stop_sel_r <= 1'b0;
      parity_mode_r <= `RX_RST_PARITY;
      char_size_r <= `RX_RST_CHAR_SIZE;
    end else if (wr_i) begin
      unique case (addr_i)
        `RX_OFS_STATUS: begin
          // Only the speed bit is stored; error bits stay untouched
          double_speed_r <= wdata_i[`RX_ST_DOUBLE_SPEED];
        end
        `RX_OFS_CTRL_B: begin
          irq_en_r <= wdata_i[`RX_CB_IRQ_EN];
          rx_enable_r <= wdata_i[`RX_CB_ENABLE];
          char_size_r[2] <= wdata_i[`RX_CB_CHAR_SIZE2];
        end
        `RX_OFS_FRAME_CFG: begin
          parity_mode_r <= wdata_i[`RX_FC_PARITY_HI:`RX_FC_PARITY_LO];
          stop_sel_r <= wdata_i[`RX_FC_STOP_SEL];
          char_size_r[1:0] <=
            wdata_i[`RX_FC_CHAR_SIZE_HI:`RX_FC_CHAR_SIZE_LO];
        end
        `RX_OFS_DATA: begin
          // Transmit side is elsewhere; writes here do nothing
        end
      endcase
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `RX_OFS_STATUS: begin
          rdata_o <= 8'h00;
          rdata_o[`RX_ST_COMPLETE] <= rx_complete;
          rdata_o[`RX_ST_FRAME_ERR] <= rx_complete & head.frame_err;
          rdata_o[`RX_ST_OVERRUN] <= rx_complete & head.overrun;
          rdata_o[`RX_ST_PARITY_ERR] <=
            rx_complete & head.parity_err;
          rdata_o[`RX_ST_DOUBLE_SPEED] <= double_speed_r;
        end
        `RX_OFS_CTRL_B: begin
          rdata_o <= 8'h00;
          rdata_o[`RX_CB_IRQ_EN] <= irq_en_r;
          rdata_o[`RX_CB_ENABLE] <= rx_enable_r;
          rdata_o[`RX_CB_CHAR_SIZE2] <= char_size_r[2];
          rdata_o[`RX_CB_NINTH_BIT] <= rx_complete & head.data[8];
        end
        `RX_OFS_FRAME_CFG: begin
          rdata_o <= {2'h0, parity_mode_r, stop_sel_r,
                      char_size_r[1:0], 1'b0};
        end
        `RX_OFS_DATA: begin
          rdata_o <= rx_complete ? head.data[7:0] : 8'h00;
        end
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ==========================================================
  // Interrupt and pin ownership, both registered
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_complete_irq_o <= 1'b0;
      pin_override_o <= 1'b0;
    end else begin
      // Error flags deliberately have no path here
      rx_complete_irq_o <= irq_en_r && rx_complete;
      pin_override_o <= rx_enable_r;
    end
  end

  // ==========================================================
  // Clock and data recovery; disable abandons any frame at once
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rx_enable_r) begin
      state_r <= uart_rx_pkg::RX_IDLE;
      ph_r <= 5'h01;
      votes_r <= 3'h0;
      prev_r <= 1'b1;
      bitn_r <= 4'h0;
      data_sh_r <= 9'h000;
      parity_bit_r <= 1'b0;
      frame_done_r <= 1'b0;
      start_ok_r <= 1'b0;
      frame_r <= '0;
    end else begin
      frame_done_r <= 1'b0;
      start_ok_r <= 1'b0;
      if (sample_tick_i) begin
        prev_r <= receive_pin_i;
        unique case (state_r)
          uart_rx_pkg::RX_IDLE: begin
            // This tick is sample 1, so the next tick is sample 2;
            // starting at 1 would vote one sample late and miss a
            // start edge that follows the stop vote directly
            if (prev_r && !receive_pin_i) begin
              state_r <= uart_rx_pkg::RX_START;
              ph_r <= 5'h02;
            end
          end
          uart_rx_pkg::RX_START, uart_rx_pkg::RX_BITS: begin
            ph_r <= (ph_r == spb) ? 5'h01 : 5'(ph_r + 5'h01);
            if (vp != 2'h0)
              votes_r <= {votes_r[1:0], receive_pin_i};
            if (vp == 2'h3) begin
              if (state_r == uart_rx_pkg::RX_START) begin
                if (vote) begin
                  state_r <= uart_rx_pkg::RX_IDLE;
                end else begin
                  state_r <= uart_rx_pkg::RX_BITS;
                  bitn_r <= 4'h0;
                  data_sh_r <= 9'h000;
                  start_ok_r <= 1'b1;
                end
              end else if (bitn_r < nd) begin
                data_sh_r[bitn_r] <= vote;
                bitn_r <= 4'(bitn_r + 4'h1);
              end else if (bitn_r == nd && parity_mode_r[1]) begin
                parity_bit_r <= vote;
                bitn_r <= 4'(bitn_r + 4'h1);
              end else begin
                // First stop bit ends the frame, whatever stop_sel says
                state_r <= uart_rx_pkg::RX_IDLE;
                frame_done_r <= 1'b1;
                frame_r.data <= data_sh_r;
                frame_r.frame_err <= !vote;
                frame_r.overrun <= 1'b0;
                frame_r.parity_err <= parity_mode_r[1] &
                  (parity_bit_r ^ (^data_sh_r) ^ parity_mode_r[0]);
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Two-entry buffer with one held frame behind it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rx_enable_r) begin
      count_r <= 2'h0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      hold_valid_r <= 1'b0;
      hold_r <= '0;
      dor_flag_r <= 1'b0;
    end else begin
      if (push) begin
        buf_r[wr_ptr_r] <= src;
        wr_ptr_r <= !wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= !rd_ptr_r;
      count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
      // A full buffer parks the finished frame in hold_r
      if (frame_done_r && !room) begin
        hold_valid_r <= 1'b1;
        hold_r <= frame_r;
      end else if (push && hold_valid_r) begin
        hold_valid_r <= 1'b0;
      end
      // New start over a parked frame loses it
      if (overrun_hit) begin
        hold_valid_r <= 1'b0;
        dor_flag_r <= 1'b1;
      end else if (push) begin
        dor_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks

  sequence s_rx_push_empty;
    push && (count_r == 2'h0) && !pop;
  endsequence

  property p_rx_complete_rise;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_rx_push_empty |=> rx_complete && (count_r == 2'h1);
  endproperty
  a_rx_complete_rise: assert property (p_rx_complete_rise)
    else $error("rx_complete did not rise after push");

  property p_flush;
    @(posedge clk_sys_i) disable iff (rst_i)
      !rx_enable_r |=> !rx_complete && (state_r == uart_rx_pkg::RX_IDLE);
  endproperty
  a_flush: assert property (p_flush)
    else $error("buffer not flushed on disable");

  property p_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
      (irq_en_r && rx_complete) [*2] |-> rx_complete_irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing while data waits");

  property p_irq_off;
    @(posedge clk_sys_i) disable iff (rst_i)
      rx_complete_irq_o |-> $past(rx_complete) && $past(irq_en_r);
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt without receive complete");

  property p_status_write;
    @(posedge clk_sys_i) disable iff (rst_i)
      wr_i && (addr_i == `RX_OFS_STATUS) && !src_valid && !pop
        |=> $stable(count_r) && $stable(rd_ptr_r);
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status write disturbed the buffer");

  sequence s_noise_start;
    (state_r == uart_rx_pkg::RX_START) && sample_tick_i &&
      (vp == 2'h3) && vote && rx_enable_r;
  endsequence

  property p_start_reject;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_noise_start |=> (state_r == uart_rx_pkg::RX_IDLE) && !start_ok_r;
  endproperty
  a_start_reject: assert property (p_start_reject)
    else $error("noise start bit accepted");

  property p_overrun;
    @(posedge clk_sys_i) disable iff (rst_i)
      overrun_hit && rx_enable_r |=> dor_flag_r && !hold_valid_r;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_overrun_clear;
    @(posedge clk_sys_i) disable iff (rst_i)
      push && !overrun_hit |=> !dor_flag_r;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("overrun kept after transfer");

  property p_phase;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_r != uart_rx_pkg::RX_IDLE |->
        (ph_r >= 5'h01) && (ph_r <= spb);
  endproperty
  a_phase: assert property (p_phase)
    else $error("recovery phase out of range");

  property p_frame_end;
    @(posedge clk_sys_i) disable iff (rst_i)
      frame_done_r |-> (state_r == uart_rx_pkg::RX_IDLE) &&
        (frame_r.parity_err -> $past(parity_mode_r[1]));
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("frame end not back to edge search");

  property p_read_data;
    @(posedge clk_sys_i) disable iff (rst_i)
      pop |=> rdata_o == $past(head.data[7:0]);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("data read did not return head entry");

endmodule
`default_nettype wire

// File: bench/uart_tx_model.sv
// Remote serial transmitter and baud tick source for the receiver.
// Assumes the receiver samples only on tick_o and idles the line high.
`timescale 1ns/1ns
`default_nettype none

module uart_tx_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  output logic tick_o,
  output logic line_o
);
  logic div_r;

  initial begin
    line_o = 1'b1;
  end

  // ==========================================================
  // Baud generator: one tick every second clock keeps runs short
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_r <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      div_r <= ~div_r;
      tick_o <= div_r;
    end
  end

  // Counts ticks as the receiver takes them at the edge
  task automatic wait_ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      while (tick_o !== 1'b1) @(posedge clk_sys_i);
    end
  endtask

  // ==========================================================
  // Frame: start, data LSB first, parity, one short stop bit
  task automatic send(input logic [8:0] d, input int nbits,
                      input logic par_en, input logic par_bit,
                      input logic stop_bit, input int spb);
    // Line changes only on a clock edge
    @(posedge clk_sys_i);
    line_o <= 1'b0;
    wait_ticks(spb);
    for (int i = 0; i < nbits; i++) begin
      line_o <= d[i];
      wait_ticks(spb);
    end
    if (par_en) begin
      line_o <= par_bit;
      wait_ticks(spb);
    end
    // Stop ends after the vote so the next start follows at once
    line_o <= stop_bit;
    wait_ticks(spb / 2 + 2);
    if (stop_bit == 1'b0) begin
      line_o <= 1'b1;
      wait_ticks(spb);
    end
  endtask

  // Short low spike that must not pass the start vote
  task automatic glitch(input int n);
    @(posedge clk_sys_i);
    line_o <= 1'b0;
    wait_ticks(n);
    line_o <= 1'b1;
    wait_ticks(16);
  endtask
endmodule
`default_nettype wire

// File: bench/uart_rx_flags_bench.sv
// Self-checking bench for the serial receiver and its register port.
// Assumes the transmitter model supplies both ticks and line.
`timescale 1ns/1ns
`default_nettype none
`include "uart_rx_regs.svh"

module uart_rx_flags_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sample_tick_i;
  logic receive_pin_i;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic rx_complete_irq_o;
  logic pin_override_o;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [1:0] par_mode [4] = '{2'h2, 2'h3, 2'h2, 2'h3};
  logic par_val [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic par_bad [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  uart_rx_flags uart_rx_flags_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sample_tick_i(sample_tick_i), .receive_pin_i(receive_pin_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_complete_irq_o(rx_complete_irq_o),
    .pin_override_o(pin_override_o)
  );

  uart_tx_model uart_tx_model_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .tick_o(sample_tick_i), .line_o(receive_pin_i)
  );

  // ==========================================================
  // Clock, reset and hang guard
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // ==========================================================
  // Register port: one-cycle strobes, read data a cycle later
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic expect_reg(input string nm, input logic [1:0] a,
                            input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    check(nm, rdata_o, exp);
  endtask

  // Settle window covers the two-edge push plus irq lag
  task automatic frame(input logic [8:0] d, input int nbits,
                       input logic pe, input logic pb, input logic sb,
                       input int spb);
    uart_tx_model_i.send(d, nbits, pe, pb, sb, spb);
    repeat (8) @(posedge clk_sys_i);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    expect_reg("status", `RX_OFS_STATUS, 8'h00);
    expect_reg("ctrl", `RX_OFS_CTRL_B, 8'h00);
    expect_reg("fcfg", `RX_OFS_FRAME_CFG, 8'h06);
    expect_reg("empty", `RX_OFS_DATA, 8'h00);
    check("pin", {7'h0, pin_override_o}, 8'h00);
    $display("test reset done");

    wr(`RX_OFS_CTRL_B, 8'h90);
    repeat (2) @(posedge clk_sys_i);
    check("pin", {7'h0, pin_override_o}, 8'h01);
    frame(9'h0a5, 8, 1'b0, 1'b0, 1'b1, 16);
    expect_reg("status", `RX_OFS_STATUS, 8'h80);
    check("irq", {7'h0, rx_complete_irq_o}, 8'h01);
    expect_reg("data", `RX_OFS_DATA, 8'ha5);
    expect_reg("status", `RX_OFS_STATUS, 8'h00);
    check("irq", {7'h0, rx_complete_irq_o}, 8'h00);
    $display("test basic done");

    uart_tx_model_i.glitch(6);
    repeat (8) @(posedge clk_sys_i);
    expect_reg("status", `RX_OFS_STATUS, 8'h00);
    frame(9'h0c3, 8, 1'b0, 1'b0, 1'b1, 16);
    expect_reg("data", `RX_OFS_DATA, 8'hc3);
    $display("test noise done");

    frame(9'h03c, 8, 1'b0, 1'b0, 1'b0, 16);
    expect_reg("status", `RX_OFS_STATUS, 8'h90);
    wr(`RX_OFS_STATUS, 8'h00);
    check("irq", {7'h0, rx_complete_irq_o}, 8'h01);
    expect_reg("status", `RX_OFS_STATUS, 8'h90);
    expect_reg("data", `RX_OFS_DATA, 8'h3c);
    wr(`RX_OFS_STATUS, 8'h00);
    expect_reg("status", `RX_OFS_STATUS, 8'h00);
    $display("test frame error done");

    // Parity 0x07 has an odd count of ones
    for (int i = 0; i < 4; i++) begin
      // Two stop bits selected; the receiver must still use one
      wr(`RX_OFS_FRAME_CFG, {2'h0, par_mode[i], 4'he});
      frame(9'h007, 8, 1'b1, par_val[i], 1'b1, 16);
      expect_reg("par", `RX_OFS_STATUS, {5'h10, par_bad[i], 2'h0});
      expect_reg("pdata", `RX_OFS_DATA, 8'h07);
    end
    $display("test parity done");

    // Characters of 5 to 8 bits read back with zero unused upper bits
    for (int cs = 0; cs < 4; cs++) begin
      wr(`RX_OFS_FRAME_CFG, {5'h00, cs[1:0], 1'b0});
      frame(9'h1ff, cs + 5, 1'b0, 1'b0, 1'b1, 16);
      expect_reg("narrow", `RX_OFS_DATA, 8'hff >> (3 - cs));
    end
    $display("test sizes done");

    wr(`RX_OFS_CTRL_B, 8'h94);
    for (int i = 0; i < 2; i++) begin
      frame({i[0], 8'ha5}, 9, 1'b0, 1'b0, 1'b1, 16);
      expect_reg("ninth", `RX_OFS_CTRL_B, {6'h25, i[0], 1'b0});
      expect_reg("low", `RX_OFS_DATA, 8'ha5);
    end
    wr(`RX_OFS_CTRL_B, 8'h90);
    $display("test ninth bit done");

    // Four frames back to back into a two-entry buffer
    uart_tx_model_i.send(9'h011, 8, 1'b0, 1'b0, 1'b1, 16);
    uart_tx_model_i.send(9'h022, 8, 1'b0, 1'b0, 1'b1, 16);
    uart_tx_model_i.send(9'h033, 8, 1'b0, 1'b0, 1'b1, 16);
    uart_tx_model_i.send(9'h044, 8, 1'b0, 1'b0, 1'b1, 16);
    repeat (8) @(posedge clk_sys_i);
    expect_reg("ov0", `RX_OFS_STATUS, 8'h80);
    expect_reg("d1", `RX_OFS_DATA, 8'h11);
    repeat (4) @(posedge clk_sys_i);
    expect_reg("ov1", `RX_OFS_STATUS, 8'h80);
    expect_reg("d2", `RX_OFS_DATA, 8'h22);
    expect_reg("ov2", `RX_OFS_STATUS, 8'h88);
    expect_reg("d4", `RX_OFS_DATA, 8'h44);
    expect_reg("ov3", `RX_OFS_STATUS, 8'h00);
    frame(9'h055, 8, 1'b0, 1'b0, 1'b1, 16);
    expect_reg("ov4", `RX_OFS_STATUS, 8'h80);
    expect_reg("d5", `RX_OFS_DATA, 8'h55);
    $display("test overrun done");

    wr(`RX_OFS_STATUS, 8'h02);
    uart_tx_model_i.send(9'h05a, 8, 1'b0, 1'b0, 1'b1, 8);
    frame(9'h0c3, 8, 1'b0, 1'b0, 1'b1, 8);
    expect_reg("ds", `RX_OFS_STATUS, 8'h82);
    expect_reg("ds1", `RX_OFS_DATA, 8'h5a);
    expect_reg("ds2", `RX_OFS_DATA, 8'hc3);
    wr(`RX_OFS_STATUS, 8'h00);
    $display("test double speed done");

    frame(9'h066, 8, 1'b0, 1'b0, 1'b1, 16);
    expect_reg("pre", `RX_OFS_STATUS, 8'h80);
    fork
      uart_tx_model_i.send(9'h077, 8, 1'b0, 1'b0, 1'b1, 16);
      begin
        repeat (120) @(posedge clk_sys_i);
        wr(`RX_OFS_CTRL_B, 8'h80);
      end
    join
    repeat (8) @(posedge clk_sys_i);
    expect_reg("flush", `RX_OFS_STATUS, 8'h00);
    check("irq", {7'h0, rx_complete_irq_o}, 8'h00);
    check("pin", {7'h0, pin_override_o}, 8'h00);
    wr(`RX_OFS_CTRL_B, 8'h90);
    repeat (40) @(posedge clk_sys_i);
    expect_reg("abandon", `RX_OFS_STATUS, 8'h00);
    check("pin", {7'h0, pin_override_o}, 8'h01);
    $display("test disable done");
    final_report();
  end
endmodule
`default_nettype wire
